// ---- rtl/ufc_pkg.sv ----
/*
  Shared constants for the UART FIFO control block: register map, control field layout,
  trigger thresholds, interrupt bits and time-out timing.
  Assumes a 50 MHz APB clock and 8-bit characters.
*/
package ufc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int INT_W = 4;
  localparam int TMO_W = 10;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX_HOLD = 8'h04;
  localparam logic [7:0] REG_RX_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_INT_STATUS = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;

  // Control register layout.
  localparam int CTRL_EN = 0;
  localparam int CTRL_RX_FLUSH = 1;
  localparam int CTRL_TX_FLUSH = 2;
  localparam int CTRL_DMA_MODE = 3;
  localparam int CTRL_TRIG_LO = 6;
  localparam int CTRL_TRIG_HI = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_USED_MASK = 8'hCF;

  // Receive thresholds per select code.
  localparam logic [CNT_W-1:0] TRIG_SEL0 = 5'h01;
  localparam logic [CNT_W-1:0] TRIG_SEL1 = 5'h04;
  localparam logic [CNT_W-1:0] TRIG_SEL2 = 5'h08;
  localparam logic [CNT_W-1:0] TRIG_SEL3 = 5'h0E;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
  localparam logic [CNT_W-1:0] HOLD_DEPTH = 5'h01;

  // Status register layout.
  localparam int ST_TX_CNT_LO = 0;
  localparam int ST_RX_CNT_LO = 8;
  localparam int ST_RX_TRIG = 16;
  localparam int ST_RX_TMO = 17;
  localparam int ST_TX_REQ_N = 18;
  localparam int ST_RX_REQ_N = 19;

  // Interrupt status and mask layout.
  localparam int INT_RX_TRIG = 0;
  localparam int INT_RX_TMO = 1;
  localparam int INT_TX_EMPTY = 2;
  localparam int INT_RX_OVERRUN = 3;
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;

  // Receive time-out timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int CHAR_TIME_NS = 2000;
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_CYC = (TIMEOUT_CHARS * CHAR_TIME_NS) / CLK_PERIOD_NS;
  localparam logic [TMO_W-1:0] TMO_LAST = 10'(TIMEOUT_CYC - 1);
endpackage

// ---- rtl/ufc_fifo_ctrl.sv ----
/*
  FIFO control for one UART channel: control register, transmit and receive FIFOs,
  receive trigger and time-out, DMA request pins, interrupt status over APB.
  Assumes the shift register logic runs on pclk and presents single-cycle strobes.
*/
// Implementation choices: the APB register port and the address map.
// Behaviour
// - Select codes 00,01,10,11 give receive thresholds 1, 4, 8 and 14.
// - Receive trigger raises at threshold; FIFO keeps filling until full.
// - Control bits 5 and 4 are unused and always zero.
// - Control bit 3 selects DMA mode 0 or block mode 1.
// - Mode 0 transmit request goes high once a character is written.
// - Mode 0 receive request is low while any received character waits.
// - Mode 1 transmit request is high only when the transmit FIFO is full.
// - Mode 1 receive request falls at threshold or time-out, rises when empty.
// - Bit 2 flushes the transmit FIFO, shift side untouched, then self-clears.
// - Bit 1 flushes the receive FIFO, shift side untouched, then self-clears.
// - Bit 0 enables both FIFOs; disabled after reset.
// - Other control bits are written only when bit 0 is written as one.
// - Receive threshold select resets to zero, the one-character level.
// - Receive trigger clears when the count falls below the threshold.
// - Mode 0 transmit request is low while transmit FIFO or holding is empty.
`timescale 1ns/1ns
module ufc_fifo_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ufc_pkg::ADDR_W-1:0] paddr,
  input wire logic [ufc_pkg::DATA_W-1:0] pwdata,
  output logic [ufc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_load_req,
  output logic tx_load_valid,
  output logic [ufc_pkg::CHAR_W-1:0] tx_load_data,
  input wire logic rx_char_valid,
  input wire logic [ufc_pkg::CHAR_W-1:0] rx_char_data,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n,
  output logic irq
);
  typedef enum logic [1:0] {
    UFC_RXQ_IDLE = 2'b01,
    UFC_RXQ_ACTIVE = 2'b10
  } ufc_rxq_t;

  logic [7:0] fifo_control_reg;
  logic [ufc_pkg::CHAR_W-1:0] tx_mem [ufc_pkg::DEPTH];
  logic [ufc_pkg::CHAR_W-1:0] rx_mem [ufc_pkg::DEPTH];
  logic [ufc_pkg::PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [ufc_pkg::CNT_W-1:0] tx_count, rx_count, cap, rx_thr;
  logic [ufc_pkg::TMO_W-1:0] tmo_cnt;
  logic [ufc_pkg::INT_W-1:0] int_status, int_mask, next_int_status, int_set;
  logic rx_timeout, rx_trig, tx_empty_q, tmo_q;
  ufc_rxq_t rxq, next_rxq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave. No wait state: read data is loaded into a flip-flop during setup.

  logic acc, wr_ctrl, wr_txh, rd_rx, wr_ists, wr_mask;
  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && (paddr == ufc_pkg::REG_CTRL);
  assign wr_txh = acc && pwrite && (paddr == ufc_pkg::REG_TX_HOLD);
  assign rd_rx = acc && !pwrite && (paddr == ufc_pkg::REG_RX_DATA);
  assign wr_ists = acc && pwrite && (paddr == ufc_pkg::REG_INT_STATUS);
  assign wr_mask = acc && pwrite && (paddr == ufc_pkg::REG_INT_MASK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      case (paddr)
        ufc_pkg::REG_CTRL: prdata[7:0] <= fifo_control_reg;
        ufc_pkg::REG_TX_HOLD: prdata <= 32'h00000000;
        ufc_pkg::REG_RX_DATA: prdata[ufc_pkg::CHAR_W-1:0] <= rx_mem[rx_rp];
        ufc_pkg::REG_STATUS: begin
          prdata[ufc_pkg::ST_TX_CNT_LO +: ufc_pkg::CNT_W] <= tx_count;
          prdata[ufc_pkg::ST_RX_CNT_LO +: ufc_pkg::CNT_W] <= rx_count;
          prdata[ufc_pkg::ST_RX_TRIG] <= rx_trig;
          prdata[ufc_pkg::ST_RX_TMO] <= rx_timeout;
          prdata[ufc_pkg::ST_TX_REQ_N] <= tx_dma_request_n;
          prdata[ufc_pkg::ST_RX_REQ_N] <= rx_dma_request_n;
        end
        ufc_pkg::REG_INT_STATUS: prdata[ufc_pkg::INT_W-1:0] <= int_status;
        ufc_pkg::REG_INT_MASK: prdata[ufc_pkg::INT_W-1:0] <= int_mask;
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register. Flush bits stand for one cycle, which is the flush itself.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_control_reg <= ufc_pkg::CTRL_RESET;
    end else begin
      fifo_control_reg[ufc_pkg::CTRL_TX_FLUSH] <= 1'b0;
      fifo_control_reg[ufc_pkg::CTRL_RX_FLUSH] <= 1'b0;
      if (wr_ctrl) begin
        if (pwdata[ufc_pkg::CTRL_EN]) begin
          fifo_control_reg <= pwdata[7:0] & ufc_pkg::CTRL_USED_MASK;
        end else begin
          fifo_control_reg[ufc_pkg::CTRL_EN] <= 1'b0;
        end
      end
    end
  end

  logic fifo_en, mode1, tx_flush, rx_flush;
  assign fifo_en = fifo_control_reg[ufc_pkg::CTRL_EN];
  assign mode1 = fifo_en && fifo_control_reg[ufc_pkg::CTRL_DMA_MODE];
  assign tx_flush = fifo_control_reg[ufc_pkg::CTRL_TX_FLUSH];
  assign rx_flush = fifo_control_reg[ufc_pkg::CTRL_RX_FLUSH];
  // With the FIFOs off only a single holding location is used.
  assign cap = fifo_en ? ufc_pkg::FIFO_DEPTH : ufc_pkg::HOLD_DEPTH;

  always_comb begin
    case (fifo_control_reg[ufc_pkg::CTRL_TRIG_HI:ufc_pkg::CTRL_TRIG_LO])
      2'b00: rx_thr = ufc_pkg::TRIG_SEL0;
      2'b01: rx_thr = ufc_pkg::TRIG_SEL1;
      2'b10: rx_thr = ufc_pkg::TRIG_SEL2;
      default: rx_thr = ufc_pkg::TRIG_SEL3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO. A flush leaves the character already handed to the shifter.

  logic tx_push, tx_pop;
  // Turning the FIFOs off leaves the count above a capacity of one, so fill is tested with less-than.
  assign tx_push = wr_txh && (tx_count < cap);
  assign tx_pop = tx_load_req && (tx_count != 5'h00);

  always_ff @(posedge pclk) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= pwdata[ufc_pkg::CHAR_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_count <= 5'h00;
    end else if (tx_flush) begin
      tx_wp <= 4'h0;
      tx_rp <= 4'h0;
      tx_count <= 5'h00;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 4'h1;
      if (tx_pop) tx_rp <= tx_rp + 4'h1;
      tx_count <= tx_count + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_load_valid <= 1'b0;
      tx_load_data <= 8'h00;
    end else begin
      tx_load_valid <= tx_pop;
      if (tx_pop) tx_load_data <= tx_mem[tx_rp];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO. A character arriving while full is dropped and reported.

  logic rx_push, rx_pop, rx_trig_lvl;
  assign rx_push = rx_char_valid && (rx_count < cap);
  assign rx_pop = rd_rx && (rx_count != 5'h00);
  assign rx_trig_lvl = fifo_en && (rx_count >= rx_thr);

  always_ff @(posedge pclk) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_char_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_count <= 5'h00;
    end else if (rx_flush) begin
      rx_wp <= 4'h0;
      rx_rp <= 4'h0;
      rx_count <= 5'h00;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 4'h1;
      if (rx_pop) rx_rp <= rx_rp + 4'h1;
      rx_count <= rx_count + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // Any arrival stored in the FIFO, or any read, restarts the quiet-time count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt <= 10'h000;
      rx_timeout <= 1'b0;
    end else if (!fifo_en || rx_flush || rx_push || rx_pop || rx_count == 5'h00) begin
      tmo_cnt <= 10'h000;
      rx_timeout <= 1'b0;
    end else if (tmo_cnt == ufc_pkg::TMO_LAST) begin
      rx_timeout <= 1'b1;
    end else begin
      tmo_cnt <= tmo_cnt + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_trig <= 1'b0;
    end else begin
      rx_trig <= rx_trig_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA request pins.

  always_comb begin
    next_rxq = rxq;
    case (rxq)
      UFC_RXQ_IDLE: if (mode1 && (rx_trig_lvl || rx_timeout)) next_rxq = UFC_RXQ_ACTIVE;
      UFC_RXQ_ACTIVE: if (!mode1 || rx_count == 5'h00) next_rxq = UFC_RXQ_IDLE;
      default: next_rxq = UFC_RXQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxq <= UFC_RXQ_IDLE;
      tx_dma_request_n <= 1'b0;
      rx_dma_request_n <= 1'b1;
    end else begin
      rxq <= next_rxq;
      if (mode1) begin
        tx_dma_request_n <= (tx_count == ufc_pkg::FIFO_DEPTH);
        rx_dma_request_n <= (next_rxq != UFC_RXQ_ACTIVE);
      end else begin
        tx_dma_request_n <= (tx_count != 5'h00);
        rx_dma_request_n <= (rx_count == 5'h00);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts. A new event wins over a write-one-to-clear in the same cycle.

  always_comb begin
    int_set = ufc_pkg::INT_RESET;
    int_set[ufc_pkg::INT_RX_TRIG] = rx_trig_lvl && !rx_trig;
    int_set[ufc_pkg::INT_RX_TMO] = rx_timeout && !tmo_q;
    int_set[ufc_pkg::INT_TX_EMPTY] = (tx_count == 5'h00) && !tx_empty_q;
    int_set[ufc_pkg::INT_RX_OVERRUN] = rx_char_valid && (rx_count >= cap);
    next_int_status = int_status;
    if (wr_ists) next_int_status = int_status & ~pwdata[ufc_pkg::INT_W-1:0];
    next_int_status = next_int_status | int_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= ufc_pkg::INT_RESET;
      int_mask <= ufc_pkg::INT_RESET;
      tmo_q <= 1'b0;
      tx_empty_q <= 1'b1;
      irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      if (wr_mask) int_mask <= pwdata[ufc_pkg::INT_W-1:0];
      tmo_q <= rx_timeout;
      tx_empty_q <= (tx_count == 5'h00);
      irq <= |(next_int_status & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence rxq_cause_s;
    mode1 && (rx_trig_lvl || rx_timeout);
  endsequence
  sequence rxq_empty_s;
    mode1 && rx_count == 5'h00;
  endsequence
  sequence tx_flush_s;
    tx_flush ##1 !tx_flush && tx_count == 5'h00;
  endsequence
  sequence rx_flush_s;
    rx_flush ##1 !rx_flush && rx_count == 5'h00;
  endsequence

  trig_decode_a: assert property (fifo_control_reg[7:6] == 2'b11 |-> rx_thr == 5'h0E)
    else $error("threshold for select 11 is not 14");
  trig_raise_a: assert property (fifo_en && rx_count == rx_thr |=> rx_trig)
    else $error("trigger not raised at threshold");
  trig_drop_a: assert property (rx_count < rx_thr |=> !rx_trig)
    else $error("trigger held below threshold");
  spare_bits_a: assert property (fifo_control_reg[5:4] == 2'b00)
    else $error("unused control bits set");
  tx_flush_a: assert property (tx_flush |=> tx_count == 5'h00 && !tx_flush)
    else $error("transmit flush incomplete");
  rx_flush_a: assert property (rx_flush |=> rx_count == 5'h00 && !rx_flush)
    else $error("receive flush incomplete");
  ctrl_guard_a: assert property (wr_ctrl && !pwdata[0] |=> !fifo_en
    && $stable(fifo_control_reg[7:6]) && $stable(fifo_control_reg[3]))
    else $error("control bits written without enable");
  tx_mode0_a: assert property (!mode1 ##1 !mode1 && $past(tx_count) != 5'h00
    |-> tx_dma_request_n)
    else $error("mode 0 transmit request not released");
  tx_empty_a: assert property (!mode1 && tx_count == 5'h00 |=> !tx_dma_request_n)
    else $error("mode 0 transmit request not low when empty");
  tx_mode1_a: assert property (mode1 && tx_count != 5'h10 |=> !tx_dma_request_n)
    else $error("mode 1 transmit request high while space left");
  rx_mode0_a: assert property (!mode1 && rx_count != 5'h00 |=> !rx_dma_request_n)
    else $error("mode 0 receive request not low with data");
  rx_mode1_a: assert property (rxq_cause_s |=> !rx_dma_request_n)
    else $error("mode 1 receive request not asserted");
  rx_release_a: assert property (rxq_empty_s |=> rx_dma_request_n)
    else $error("mode 1 receive request not released when empty");
  rx_timeout_a: assert property (fifo_en && rx_count != 5'h00 && !rx_push && !rx_pop
    && !rx_flush && tmo_cnt == ufc_pkg::TMO_LAST |=> rx_timeout)
    else $error("receive time-out missed");
  tx_flush_req_a: assert property (wr_ctrl && pwdata[ufc_pkg::CTRL_EN]
    && pwdata[ufc_pkg::CTRL_TX_FLUSH] |=> tx_flush_s)
    else $error("transmit flush not carried out");
  rx_flush_req_a: assert property (wr_ctrl && pwdata[ufc_pkg::CTRL_EN]
    && pwdata[ufc_pkg::CTRL_RX_FLUSH] |=> rx_flush_s)
    else $error("receive flush not carried out");
  rx_overrun_a: assert property (rx_char_valid && rx_count >= cap
    |=> int_status[ufc_pkg::INT_RX_OVERRUN])
    else $error("receive overrun not reported");
  int_sticky_a: assert property (int_set != 4'h0
    |=> (int_status & $past(int_set)) == $past(int_set))
    else $error("interrupt event lost");
  irq_high_a: assert property ($stable(int_mask) && (int_status & int_mask) != 4'h0 |-> irq)
    else $error("interrupt low while unmasked status set");
  irq_low_a: assert property ($stable(int_mask) && (int_status & int_mask) == 4'h0 |-> !irq)
    else $error("interrupt high with no unmasked status");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no access phase answer after setup");
  tx_full_a: assert property (mode1 && tx_count == 5'h10 |=> tx_dma_request_n)
    else $error("mode 1 transmit request low while full");
  rx_empty_a: assert property (!mode1 && rx_count == 5'h00 |=> rx_dma_request_n)
    else $error("mode 0 receive request low while empty");
endmodule

// ---- tb/ufc_shift_model.sv ----
/*
  Shifter-side partner: feeds received characters and pulls transmit characters.
  Assumes pclk comes from the bench and that the bench calls push and pull.
*/
`timescale 1ns/1ns
module ufc_shift_model (
  input wire logic pclk,
  output logic tx_load_req,
  input wire logic tx_load_valid,
  input wire logic [ufc_pkg::CHAR_W-1:0] tx_load_data,
  output logic rx_char_valid,
  output logic [ufc_pkg::CHAR_W-1:0] rx_char_data
);
  initial begin
    tx_load_req = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
  end
  // Data flips once the strobe drops, so a stale byte can never pass for a fresh one.
  task push(input logic [ufc_pkg::CHAR_W-1:0] d);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~d;
  endtask
  task pull(output logic [ufc_pkg::CHAR_W-1:0] d);
    int n;
    @(posedge pclk);
    tx_load_req <= 1'b1;
    @(posedge pclk);
    tx_load_req <= 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (tx_load_valid !== 1'b1 && n < 4);
    d = tx_load_data;
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Self-checking bench for the FIFO control block, driven over APB.
  Assumes the shifter model in ufc_shift_model and a 50 MHz pclk.
*/
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slverr;
  logic tx_load_req, tx_load_valid, rx_char_valid, tx_dma_request_n, rx_dma_request_n;
  logic [7:0] paddr, tx_load_data, rx_char_data, c;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] tx_holding_reg [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int miscompares = 0;
  int checked = 0;
  ufc_fifo_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_load_req(tx_load_req), .tx_load_valid(tx_load_valid),
    .tx_load_data(tx_load_data), .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .tx_dma_request_n(tx_dma_request_n), .rx_dma_request_n(rx_dma_request_n), .irq(irq));
  ufc_shift_model i_shift (.pclk(pclk), .tx_load_req(tx_load_req),
    .tx_load_valid(tx_load_valid), .tx_load_data(tx_load_data),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Each transfer opens one edge after the last closed, so no signal is set twice in a step.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    slverr = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task pins(input logic tx, input logic rx);
    repeat (2) @(negedge pclk);
    chk({30'h0, tx_dma_request_n, rx_dma_request_n}, {30'h0, tx, rx});
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ufc_pkg::REG_CTRL);
    chk(q, 32'h00000000);
    pins(1'b0, 1'b1);
    wr(ufc_pkg::REG_CTRL, 32'h000000C8);
    rd(ufc_pkg::REG_CTRL);
    chk(q, 32'h00000000);
    wr(ufc_pkg::REG_CTRL, 32'h000000FF);
    rd(ufc_pkg::REG_CTRL);
    chk(q, 32'h000000C9);
    $display("test control done");
    i_shift.push(8'h5A);
    pins(1'b0, 1'b1);
    repeat (380) @(negedge pclk);
    chkb(rx_dma_request_n, 1'b1);
    repeat (30) @(negedge pclk);
    chkb(rx_dma_request_n, 1'b0);
    rd(ufc_pkg::REG_STATUS);
    chkb(q[17], 1'b1);
    rd(ufc_pkg::REG_RX_DATA);
    chk(q, 32'h0000005A);
    pins(1'b0, 1'b1);
    $display("test timeout done");
    for (int i = 0; i < 16; i++)
      wr(ufc_pkg::REG_TX_HOLD, 32'h000000B0 + 32'(i));
    pins(1'b1, 1'b1);
    i_shift.pull(c);
    chk({24'h0, c}, 32'h000000B0);
    pins(1'b0, 1'b1);
    wr(ufc_pkg::REG_CTRL, 32'h000000CD);
    rd(ufc_pkg::REG_STATUS);
    chk({27'h0, q[4:0]}, 32'h00000000);
    wr(ufc_pkg::REG_CTRL, 32'h00000007);
    pins(1'b0, 1'b1);
    wr(ufc_pkg::REG_TX_HOLD, 32'h00000033);
    pins(1'b1, 1'b1);
    i_shift.pull(c);
    chk({24'h0, c}, 32'h00000033);
    pins(1'b0, 1'b1);
    $display("test transmit done");
    for (int s = 0; s < 4; s++) begin
      wr(ufc_pkg::REG_CTRL, {24'h0, 2'(s), 6'h07});
      for (int i = 0; i < int'(tx_holding_reg[s]) - 1; i++)
        i_shift.push(8'hA0 + 8'(i));
      rd(ufc_pkg::REG_STATUS);
      chkb(q[16], 1'b0);
      i_shift.push(8'hA0 + 8'(tx_holding_reg[s]) - 8'h01);
      rd(ufc_pkg::REG_STATUS);
      chkb(q[16], 1'b1);
      pins(1'b0, 1'b0);
      rd(ufc_pkg::REG_RX_DATA);
      chk(q, 32'h000000A0);
      rd(ufc_pkg::REG_STATUS);
      chkb(q[16], 1'b0);
    end
    repeat (3) i_shift.push(8'h77);
    rd(ufc_pkg::REG_STATUS);
    chk({27'h0, q[12:8]}, 32'h00000010);
    wr(ufc_pkg::REG_CTRL, 32'h000000C3);
    rd(ufc_pkg::REG_STATUS);
    chk({27'h0, q[12:8]}, 32'h00000000);
    pins(1'b0, 1'b1);
    $display("test threshold done");
    wr(ufc_pkg::REG_CTRL, 32'h0000004B);
    repeat (3) i_shift.push(8'h11);
    pins(1'b0, 1'b1);
    i_shift.push(8'h12);
    pins(1'b0, 1'b0);
    repeat (3) rd(ufc_pkg::REG_RX_DATA);
    pins(1'b0, 1'b0);
    rd(ufc_pkg::REG_RX_DATA);
    chk(q, 32'h00000012);
    pins(1'b0, 1'b1);
    $display("test block mode done");
    rd(ufc_pkg::REG_INT_STATUS);
    chk(q, 32'h00000007);
    wr(ufc_pkg::REG_INT_STATUS, 32'h0000000F);
    wr(ufc_pkg::REG_INT_MASK, 32'h00000000);
    wr(ufc_pkg::REG_CTRL, 32'h00000007);
    i_shift.push(8'h44);
    rd(ufc_pkg::REG_INT_STATUS);
    chk(q, 32'h00000001);
    chkb(irq, 1'b0);
    wr(ufc_pkg::REG_INT_MASK, 32'h00000001);
    repeat (2) @(negedge pclk);
    chkb(irq, 1'b1);
    wr(ufc_pkg::REG_INT_STATUS, 32'h00000001);
    repeat (2) @(negedge pclk);
    chkb(irq, 1'b0);
    rd(8'h20);
    chkb(slverr, 1'b1);
    wr(ufc_pkg::REG_CTRL, 32'h00000000);
    i_shift.push(8'h55);
    rd(ufc_pkg::REG_INT_STATUS);
    chk(q, 32'h00000008);
    chkb(irq, 1'b0);
    pins(1'b0, 1'b0);
    rd(ufc_pkg::REG_RX_DATA);
    chk(q, 32'h00000044);
    $display("test interrupt done");
    test_done();
  end
endmodule
